// file: design/rmi_defs.svh
/*
 * Constants for the register-move execution block: bus offsets, field
 * positions, reset values, address map and phase timing.
 * Assumes a 100 MHz system clock and four clocks per instruction cycle.
 */
`ifndef RMI_DEFS_SVH
`define RMI_DEFS_SVH

// Register byte offsets
`define RMI_CTRL_OFS 8'h00
`define RMI_BANK_OFS 8'h04
`define RMI_WREG_OFS 8'h08
`define RMI_STATUS_OFS 8'h0c
`define RMI_INDEX_OFS 8'h10
`define RMI_INSTR_OFS 8'h14
`define RMI_MEMADDR_OFS 8'h18
`define RMI_MEMDATA_OFS 8'h1c

// Status field positions
`define RMI_ST_BUSY 0
`define RMI_ST_WAIT2 1
`define RMI_ST_ZERO 2
`define RMI_ST_NEG 3

// Reset values
`define RMI_W_RST 8'h00
`define RMI_BANK_RST 4'h0
`define RMI_INDEX_RST 12'h000

// Data address map
`define RMI_WREG_ADDR 12'hfe8
`define RMI_ACC_LIMIT 8'h60
`define RMI_IDX_LIMIT 8'h5f
`define RMI_ACC_HI_BANK 4'hf

// Opcode fields
`define RMI_OP_MOVE_REG 6'h14
`define RMI_OP_FF_FIRST 4'hc
`define RMI_OP_FF_SECOND 4'hf

// Quarter phases within one instruction cycle
`define RMI_Q_READ 2'h1
`define RMI_Q_WRITE 2'h3

`endif

// file: design/rmi_move_exec.sv
/*
 * Execution engine for the single-register move and the two-word
 * file-to-file move, with its own 4096-byte data memory and a classic
 * Wishbone slave for control, instruction issue and memory access.
 * Assumes a synchronous Wishbone master on clk_sys_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rmi_defs.svh"

module rmi_move_exec #(
    parameter int MEM_DEPTH = 4096
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic busy_o
);

    rmi_pkg::rmi_state_s r_reg;
    rmi_pkg::rmi_state_s r_next;

    // Data memory, no reset
    logic [7:0] mem [MEM_DEPTH];
    logic mem_we;
    logic [11:0] mem_waddr;
    logic [7:0] mem_wdata;

    logic [11:0] one_addr;
    logic [11:0] eng_addr;
    logic [7:0] eng_rdata;
    logic [7:0] bus_rdata;
    logic bus_req;
    logic bus_wr;

    // Merge byte lanes 0 and 1 into a 16-bit field
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        logic [15:0] m;
        m = old;
        if (sel[0])
        begin
            m[7:0] = d[7:0];
        end
        if (sel[1])
        begin
            m[15:8] = d[15:8];
        end
        return m;
    endfunction

    // Effective address of the single-register move
    always_comb
    begin
        one_addr = {r_reg.bank_select_reg, r_reg.word1[7:0]};
        if (!r_reg.word1[8])
        begin
            if (r_reg.ext_en && r_reg.word1[7:0] <= `RMI_IDX_LIMIT)
            begin
                one_addr = r_reg.idx + {4'h0, r_reg.word1[7:0]};
            end
            else if (r_reg.word1[7:0] < `RMI_ACC_LIMIT)
            begin
                one_addr = {4'h0, r_reg.word1[7:0]};
            end
            else
            begin
                one_addr = {`RMI_ACC_HI_BANK, r_reg.word1[7:0]};
            end
        end
    end

    // Engine and bus read ports; working register mapped in data space
    assign eng_addr = (r_reg.st == rmi_pkg::RMI_FF1) ? r_reg.word1[11:0] : one_addr;
    assign eng_rdata = (eng_addr == `RMI_WREG_ADDR) ? r_reg.w : mem[eng_addr];
    assign bus_rdata = (r_reg.memaddr == `RMI_WREG_ADDR) ? r_reg.w : mem[r_reg.memaddr];

    // Bus request and write strobe at the acknowledging edge
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_wr = bus_req & wb_we_i & r_reg.ack;

    // Next-state logic: bus slave, then engine
    always_comb
    begin
        logic [15:0] m;
        logic wr_en;
        logic [11:0] wr_addr;
        logic [7:0] wr_data;
        m = 16'h0000;
        wr_en = 1'b0;
        wr_addr = 12'h000;
        wr_data = 8'h00;
        r_next = r_reg;
        mem_we = 1'b0;
        mem_waddr = 12'h000;
        mem_wdata = 8'h00;
        r_next.q = r_reg.q + 2'h1;

        // Acknowledge one cycle after the request, drop afterwards
        r_next.ack = bus_req & ~r_reg.ack;
        r_next.dat = 32'h0000_0000;
        if (bus_req & ~r_reg.ack & ~wb_we_i)
        begin
            case (wb_adr_i)
                `RMI_CTRL_OFS: r_next.dat = {31'h0000_0000, r_reg.ext_en};
                `RMI_BANK_OFS: r_next.dat = {28'h000_0000, r_reg.bank_select_reg};
                `RMI_WREG_OFS: r_next.dat = {24'h00_0000, r_reg.w};
                `RMI_STATUS_OFS: r_next.dat = {28'h000_0000, r_reg.neg, r_reg.zero,
                                               r_reg.st == rmi_pkg::RMI_WAIT2, r_reg.busy};
                `RMI_INDEX_OFS: r_next.dat = {20'h0_0000, r_reg.idx};
                `RMI_INSTR_OFS: r_next.dat = {16'h0000, r_reg.word1};
                `RMI_MEMADDR_OFS: r_next.dat = {20'h0_0000, r_reg.memaddr};
                `RMI_MEMDATA_OFS: r_next.dat = {24'h00_0000, bus_rdata};
                default: r_next.dat = 32'h0000_0000;
            endcase
        end

        // Register writes
        if (bus_wr)
        begin
            case (wb_adr_i)
                `RMI_CTRL_OFS:
                begin
                    if (wb_sel_i[0])
                    begin
                        r_next.ext_en = wb_dat_i[0];
                    end
                end
                `RMI_BANK_OFS:
                begin
                    if (wb_sel_i[0])
                    begin
                        r_next.bank_select_reg = wb_dat_i[3:0];
                    end
                end
                `RMI_WREG_OFS:
                begin
                    if (wb_sel_i[0])
                    begin
                        r_next.w = wb_dat_i[7:0];
                    end
                end
                `RMI_INDEX_OFS:
                begin
                    m = merge16({4'h0, r_reg.idx}, wb_dat_i, wb_sel_i);
                    r_next.idx = m[11:0];
                end
                `RMI_MEMADDR_OFS:
                begin
                    m = merge16({4'h0, r_reg.memaddr}, wb_dat_i, wb_sel_i);
                    r_next.memaddr = m[11:0];
                end
                `RMI_MEMDATA_OFS:
                begin
                    if (wb_sel_i[0] && r_reg.st == rmi_pkg::RMI_IDLE)
                    begin
                        wr_en = 1'b1;
                        wr_addr = r_reg.memaddr;
                        wr_data = wb_dat_i[7:0];
                    end
                end
                `RMI_INSTR_OFS:
                begin
                    m = merge16(16'h0000, wb_dat_i, wb_sel_i);
                    // Decode first word when idle
                    if (r_reg.st == rmi_pkg::RMI_IDLE)
                    begin
                        if (m[15:10] == `RMI_OP_MOVE_REG)
                        begin
                            r_next.word1 = m;
                            r_next.st = rmi_pkg::RMI_ARM_ONE;
                        end
                        else if (m[15:12] == `RMI_OP_FF_FIRST)
                        begin
                            r_next.word1 = m;
                            r_next.st = rmi_pkg::RMI_WAIT2;
                        end
                    end
                    // Second word carries the destination
                    else if (r_reg.st == rmi_pkg::RMI_WAIT2)
                    begin
                        if (m[15:12] == `RMI_OP_FF_SECOND)
                        begin
                            r_next.dst = m[11:0];
                            r_next.st = rmi_pkg::RMI_ARM_FF;
                        end
                        else
                        begin
                            r_next.st = rmi_pkg::RMI_IDLE;
                        end
                    end
                end
                default:
                begin
                    r_next.dat = 32'h0000_0000;
                end
            endcase
        end

        // Engine sequencing on quarter phases
        case (r_reg.st)
            rmi_pkg::RMI_ARM_ONE:
            begin
                if (r_reg.q == `RMI_Q_WRITE)
                begin
                    r_next.st = rmi_pkg::RMI_ONE;
                end
            end
            rmi_pkg::RMI_ONE:
            begin
                if (r_reg.q == `RMI_Q_READ)
                begin
                    r_next.data = eng_rdata;
                end
                if (r_reg.q == `RMI_Q_WRITE)
                begin
                    wr_en = 1'b1;
                    wr_data = r_reg.data;
                    wr_addr = r_reg.word1[9] ? one_addr : `RMI_WREG_ADDR;
                    r_next.neg = r_reg.data[7];
                    r_next.zero = (r_reg.data == 8'h00);
                    r_next.st = rmi_pkg::RMI_IDLE;
                end
            end
            rmi_pkg::RMI_ARM_FF:
            begin
                if (r_reg.q == `RMI_Q_WRITE)
                begin
                    r_next.st = rmi_pkg::RMI_FF1;
                end
            end
            rmi_pkg::RMI_FF1:
            begin
                if (r_reg.q == `RMI_Q_READ)
                begin
                    r_next.data = eng_rdata;
                end
                if (r_reg.q == `RMI_Q_WRITE)
                begin
                    r_next.st = rmi_pkg::RMI_FF2;
                end
            end
            rmi_pkg::RMI_FF2:
            begin
                // No read in this cycle; write in the last quarter
                if (r_reg.q == `RMI_Q_WRITE)
                begin
                    wr_en = 1'b1;
                    wr_addr = r_reg.dst;
                    wr_data = r_reg.data;
                    r_next.st = rmi_pkg::RMI_IDLE;
                end
            end
            default:
            begin
                r_next.data = r_reg.data;
            end
        endcase

        // Route a data-space write to W or memory
        if (wr_en)
        begin
            if (wr_addr == `RMI_WREG_ADDR)
            begin
                r_next.w = wr_data;
            end
            else
            begin
                mem_we = 1'b1;
                mem_waddr = wr_addr;
                mem_wdata = wr_data;
            end
        end
        r_next.busy = (r_next.st != rmi_pkg::RMI_IDLE);
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            r_reg <= '{st: rmi_pkg::RMI_IDLE, q: 2'h0, word1: 16'h0000, dst: 12'h000,
                       data: 8'h00, w: `RMI_W_RST, bank_select_reg: `RMI_BANK_RST, ext_en: 1'b0,
                       idx: `RMI_INDEX_RST, neg: 1'b0, zero: 1'b0, memaddr: 12'h000,
                       ack: 1'b0, dat: 32'h0000_0000, busy: 1'b0};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Memory write port
    always_ff @(posedge clk_sys_i)
    begin
        if (mem_we)
        begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // Outputs straight from flip-flops
    assign wb_dat_o = r_reg.dat;
    assign wb_ack_o = r_reg.ack;
    assign busy_o = r_reg.busy;

endmodule // rmi_move_exec

`default_nettype wire

// file: design/rmi_pkg.sv
/*
 * Types for the register-move execution block: engine states and the
 * packed state record of the top module.
 * Assumes the constants header is included by the design file.
 */
`default_nettype none
package rmi_pkg;

    // Engine states
    typedef enum logic [2:0] {
        RMI_IDLE,
        RMI_WAIT2,
        RMI_ARM_ONE,
        RMI_ONE,
        RMI_ARM_FF,
        RMI_FF1,
        RMI_FF2
    } rmi_state_e;

    // All flip-flops of the top module except the data memory
    typedef struct packed {
        rmi_state_e st;
        logic [1:0] q;
        logic [15:0] word1;
        logic [11:0] dst;
        logic [7:0] data;
        logic [7:0] w;
        logic [3:0] bank_select_reg;
        logic ext_en;
        logic [11:0] idx;
        logic neg;
        logic zero;
        logic [11:0] memaddr;
        logic ack;
        logic [31:0] dat;
        logic busy;
    } rmi_state_s;

endpackage

`default_nettype wire

// file: dv/register_move_instructions_test.sv
/* Directed bench for rmi_move_exec: moves issued over Wishbone.
   Assumes the design and its header are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
`include "rmi_defs.svh"
module register_move_instructions_test;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic busy_o;
    int num_errors = 0;
    int checks_done = 0;
    rmi_move_exec dut_u (.clk_sys_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy_o);
    // Clock
    initial forever #5 clk_sys_i = ~clk_sys_i;
    // Verdict
    task end_sim;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One classic cycle, held until ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // Wait for ack; only the watchdog ends a hung wait
        do
        begin
            @(posedge clk_sys_i);
        end
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic mw(input logic [11:0] a, input logic [7:0] v);
        wr(`RMI_MEMADDR_OFS, {20'h0, a});
        wr(`RMI_MEMDATA_OFS, {24'h0, v});
    endtask
    task automatic mr(input logic [11:0] a, input logic [7:0] v);
        wr(`RMI_MEMADDR_OFS, {20'h0, a});
        rd(`RMI_MEMDATA_OFS, {24'h0, v});
    endtask
    // Poll until the engine is idle
    task automatic idle;
        logic [31:0] q;
        int n;
        n = 0;
        do
        begin
            bus(1'b0, `RMI_STATUS_OFS, 32'h0, q);
            n++;
        end
        while (q[0] !== 1'b0 && n < 30);
        if (q[0] !== 1'b0)
        begin
            num_errors++;
            $display("mismatch at %0t: engine stays busy", $time);
        end
    endtask
    task automatic one(input logic d, input logic a, input logic [7:0] f);
        wr(`RMI_INSTR_OFS, {16'h0, `RMI_OP_MOVE_REG, d, a, f});
        idle();
    endtask
    task automatic ff(input logic [11:0] s, input logic [3:0] op, input logic [11:0] t);
        wr(`RMI_INSTR_OFS, {16'h0, `RMI_OP_FF_FIRST, s});
        wr(`RMI_INSTR_OFS, {16'h0, op, t});
        idle();
    endtask
    task automatic st(input logic n, input logic z);
        rd(`RMI_STATUS_OFS, {28'h0, n, z, 2'b00});
    endtask
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        num_errors++;
        end_sim();
    end
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        rd(`RMI_CTRL_OFS, 32'h0);
        rd(`RMI_BANK_OFS, 32'h0);
        rd(`RMI_WREG_OFS, 32'h0);
        st(1'b0, 1'b0);
        wr(8'h20, 32'h5a);
        rd(8'h20, 32'h0);
        wr(`RMI_BANK_OFS, 32'h2);
        mw(12'h2ff, 8'h00);
        wr(`RMI_WREG_OFS, 32'h77);
        one(1'b0, 1'b1, 8'hff);
        rd(`RMI_WREG_OFS, 32'h0);
        st(1'b0, 1'b1);
        mw(12'h205, 8'h80);
        one(1'b0, 1'b1, 8'h05);
        rd(`RMI_WREG_OFS, 32'h80);
        st(1'b1, 1'b0);
        mw(12'h210, 8'h33);
        one(1'b1, 1'b1, 8'h10);
        mr(12'h210, 8'h33);
        rd(`RMI_WREG_OFS, 32'h80);
        st(1'b0, 1'b0);
        mw(12'h010, 8'h44);
        one(1'b0, 1'b0, 8'h10);
        rd(`RMI_WREG_OFS, 32'h44);
        mw(12'hf70, 8'h5a);
        one(1'b0, 1'b0, 8'h70);
        rd(`RMI_WREG_OFS, 32'h5a);
        wr(`RMI_CTRL_OFS, 32'h1);
        wr(`RMI_INDEX_OFS, 32'h300);
        rd(`RMI_CTRL_OFS, 32'h1);
        rd(`RMI_INDEX_OFS, 32'h300);
        mw(12'h35f, 8'h6c);
        one(1'b0, 1'b0, 8'h5f);
        rd(`RMI_WREG_OFS, 32'h6c);
        mw(12'hf60, 8'h71);
        one(1'b0, 1'b0, 8'h60);
        rd(`RMI_WREG_OFS, 32'h71);
        mw(12'h25f, 8'h00);
        one(1'b0, 1'b1, 8'h5f);
        rd(`RMI_WREG_OFS, 32'h0);
        mw(12'h123, 8'h9e);
        wr(`RMI_INSTR_OFS, {16'h0, `RMI_OP_FF_FIRST, 12'h123});
        rd(`RMI_STATUS_OFS, 32'h7);
        chk({31'h0, busy_o}, 32'h1);
        wr(`RMI_INSTR_OFS, {16'h0, `RMI_OP_FF_SECOND, 12'habc});
        idle();
        mr(12'habc, 8'h9e);
        chk({31'h0, busy_o}, 32'h0);
        st(1'b0, 1'b1);
        ff(12'h123, `RMI_OP_FF_SECOND, `RMI_WREG_ADDR);
        rd(`RMI_WREG_OFS, 32'h9e);
        ff(`RMI_WREG_ADDR, `RMI_OP_FF_SECOND, 12'h400);
        mr(12'h400, 8'h9e);
        mw(12'h500, 8'h11);
        ff(12'h123, 4'h0, 12'h500);
        mr(12'h500, 8'h11);
        end_sim();
    end
endmodule // register_move_instructions_test
`default_nettype wire

// file: dv/rmi_move_exec_props.sv
/* Bus timing and engine completion checks for rmi_move_exec.
   Assumes one clock and a master that holds each request until ack. */
`timescale 1ns/1ps
`default_nettype none
`include "rmi_defs.svh"
module rmi_move_exec_props (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    // Accepted request, instruction word issues
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ins;
        wb_ack_o && wb_we_i && wb_adr_i == `RMI_INSTR_OFS && wb_sel_i[1:0] == 2'h3;
    endsequence
    sequence s_one;
        s_ins ##0 (!busy_o && wb_dat_i[15:10] == `RMI_OP_MOVE_REG);
    endsequence
    sequence s_ff2;
        s_ins ##0 (busy_o && wb_dat_i[15:12] == `RMI_OP_FF_SECOND);
    endsequence
    a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h20
        |-> wb_dat_o == 32'h0) else $error("unmapped read nonzero");
    a_byte_narrow: assert property (wb_ack_o && !wb_we_i && (wb_adr_i == `RMI_WREG_OFS ||
        wb_adr_i == `RMI_MEMDATA_OFS) |-> wb_dat_o[31:8] == 24'h0) else $error("wide byte");
    a_flags_excl: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `RMI_STATUS_OFS
        |-> !(wb_dat_o[`RMI_ST_ZERO] && wb_dat_o[`RMI_ST_NEG])) else $error("N and Z");
    a_one_done: assert property (s_one |-> ##[1:16] $fell(busy_o)) else $error("move hung");
    a_ff_done: assert property (s_ff2 |-> ##[1:20] $fell(busy_o)) else $error("ff hung");
endmodule // rmi_move_exec_props
bind rmi_move_exec rmi_move_exec_props chk_u (.clk_sys_i, .resetn_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy_o);
`default_nettype wire
